// >>> logic/bmfs_flags.sv
// Operation
// - imprecise or fetch error captures no address
// - imprecise fault pends until priority allows
// - precise and imprecise flags may coexist
// - precise error sets bit 9, captures address
// - fetch error flagged only when issued
// - bit 7 set by any data violation, even when a stacking violation blocks the memfault address capture
// - stacking violation sets bit 4, no address
// - flags reset zero, write one clears
// - bits 6:5 reserved, read zero
// - imprecise data error sets bit 10
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "bmfs_cfg.svh"
module bmfs_flags (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core fault events
  input wire logic impreciseErr,
  input wire logic preciseErr,
  input wire logic [31:0] preciseAddr,
  input wire logic fetchErr,
  input wire logic fetchIssue,
  input wire logic fetchDiscard,
  input wire logic mmDataViol,
  input wire logic [31:0] mmDataAddr,
  input wire logic stackViol,
  // priorities
  input wire bmfs_pkg::bmfs_prio_t curPrio,
  // fault activation and interrupt
  output logic busFaultActivate,
  output logic busFaultPending,
  output logic irq
);
  import bmfs_pkg::*;
  bmfs_flags_t flags_reg;
  bmfs_flags_t flags_next;
  logic [31:0] bfAddr_reg;
  logic [31:0] memfault_address_reg_reg;
  logic [4:0] irqStat_reg;
  logic [4:0] irqEn_reg;
  bmfs_prio_t prio_reg;
  logic fetchHeld_reg;
  logic actRaw;
  logic pendRaw;

  // bus decode
  wire logic wrEn = psel & penable & pwrite;
  wire logic rdEn = psel & penable & ~pwrite;
  wire logic hitStatus = (paddr == `BMFS_OFF_STATUS);
  wire logic hitBf = (paddr == `BMFS_OFF_BFADDR);
  wire logic hitMm = (paddr == `BMFS_OFF_MEMFAULT_ADDRESS_REG);
  wire logic hitIs = (paddr == `BMFS_OFF_IRQ_STAT);
  wire logic hitIe = (paddr == `BMFS_OFF_IRQ_EN);
  wire logic hitIc = (paddr == `BMFS_OFF_IRQ_CLR);
  wire logic hitPr = (paddr == `BMFS_OFF_PRIO);
  wire logic mapped = hitStatus | hitBf | hitMm | hitIs | hitIe | hitIc | hitPr;

  // write-one-to-clear mask; reserved bits never cleared or set
  wire bmfs_flags_t clrMask = (wrEn & hitStatus) ?
    (pwdata[10:0] & `BMFS_FLAG_MASK) : `BMFS_FLAG_RST;

  // fetch error held until the instruction is issued or dropped
  wire logic fetchHit = (fetchHeld_reg | fetchErr) & fetchIssue;

  // hardware set events
  wire bmfs_flags_t setMask = ({10'h000, impreciseErr} << `BMFS_BIT_IMPRECISE_BUS_ERR_FLAG)
    | ({10'h000, preciseErr} << `BMFS_BIT_PRECISE)
    | ({10'h000, fetchHit} << `BMFS_BIT_FETCH)
    | ({10'h000, mmDataViol} << `BMFS_BIT_MMAV)
    | ({10'h000, stackViol} << `BMFS_BIT_STACK);

  // set wins over clear; other flags untouched by new faults
  assign flags_next = ((flags_reg & ~clrMask) | setMask) & `BMFS_FLAG_MASK;

  // address capture: precise data error only, never imprecise/fetch
  wire logic capBf = preciseErr;
  // memfault address only for data violations, not stacking
  wire logic capMm = mmDataViol & ~stackViol;

  // interrupt event sources
  wire logic [4:0] evVec = {impreciseErr, preciseErr, fetchHit, mmDataViol, stackViol};
  wire logic [4:0] icMask = (wrEn & hitIc) ? pwdata[4:0] : 5'h00;

  // read mux
  wire logic [31:0] rdMux = hitStatus ? {21'h0, flags_reg}
    : hitBf ? bfAddr_reg
    : hitMm ? memfault_address_reg_reg
    : hitIs ? {27'h0, irqStat_reg}
    : hitIe ? {27'h0, irqEn_reg}
    : hitPr ? {24'h0, prio_reg}
    : 32'h00000000;
  // read data launched at the setup edge so it stands with pready
  wire logic rdSetup = psel & ~penable & ~pwrite;

  // imprecise fault pending tracker
  bmfs_pend uPend (
    .clk(clk),
    .nrst(nrst),
    .faultIn(impreciseErr),
    .curPrio(curPrio),
    .busPrio(prio_reg),
    .activate(actRaw),
    .pending(pendRaw)
  );

  // fault flags
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) flags_reg <= `BMFS_FLAG_RST;
    else flags_reg <= flags_next;
  end

  // fetch error holding
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) fetchHeld_reg <= 1'b0;
    else if (fetchIssue | fetchDiscard) fetchHeld_reg <= 1'b0;
    else if (fetchErr) fetchHeld_reg <= 1'b1;
  end

  // fault address capture
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bfAddr_reg <= `BMFS_ADDR_RST;
      memfault_address_reg_reg <= `BMFS_ADDR_RST;
    end else begin
      if (capBf) bfAddr_reg <= preciseAddr;
      if (capMm) memfault_address_reg_reg <= mmDataAddr;
    end
  end

  // interrupt status, enable, priority
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqStat_reg <= 5'h00;
      irqEn_reg <= 5'h00;
      prio_reg <= `BMFS_PRIO_RST;
    end else begin
      irqStat_reg <= (irqStat_reg & ~icMask) | evVec;
      if (wrEn & hitIe) irqEn_reg <= pwdata[4:0];
      if (wrEn & hitPr) prio_reg <= pwdata[7:0];
    end
  end

  // registered outputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      busFaultActivate <= 1'b0;
      busFaultPending <= 1'b0;
    end else begin
      prdata <= rdSetup ? rdMux : 32'h00000000;
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      irq <= |(((irqStat_reg & ~icMask) | evVec) & irqEn_reg);
      busFaultActivate <= actRaw;
      busFaultPending <= pendRaw;
    end
  end
endmodule
`default_nettype wire

// >>> logic/bmfs_cfg.svh
`ifndef BMFS_CFG_SVH
`define BMFS_CFG_SVH
// register byte offsets
`define BMFS_OFF_STATUS 12'h000
`define BMFS_OFF_BFADDR 12'h004
`define BMFS_OFF_MEMFAULT_ADDRESS_REG 12'h008
`define BMFS_OFF_IRQ_STAT 12'h00c
`define BMFS_OFF_IRQ_EN 12'h010
`define BMFS_OFF_IRQ_CLR 12'h014
`define BMFS_OFF_PRIO 12'h018
// flag bit positions
`define BMFS_BIT_IMPRECISE_BUS_ERR_FLAG 10
`define BMFS_BIT_PRECISE 9
`define BMFS_BIT_FETCH 8
`define BMFS_BIT_MMAV 7
`define BMFS_BIT_STACK 4
// writable flag mask, reserved bits 6:5 excluded
`define BMFS_FLAG_MASK 11'h790
`define BMFS_FLAG_RST 11'h000
`define BMFS_ADDR_RST 32'h00000000
`define BMFS_PRIO_RST 8'h00
`endif

// >>> logic/bmfs_pkg.sv
package bmfs_pkg;
  typedef logic [10:0] bmfs_flags_t;
  typedef logic [7:0] bmfs_prio_t;
  // pending-fault tracker states
  typedef enum logic [1:0] {
    BMFS_IDLE = 2'b00,
    BMFS_PEND = 2'b01,
    BMFS_FIRE = 2'b10
  } bmfs_state_t;
endpackage

// >>> logic/bmfs_pend.sv
`timescale 1ns/1ps
`default_nettype none
module bmfs_pend (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // imprecise fault and priorities
  input wire logic faultIn,
  input wire bmfs_pkg::bmfs_prio_t curPrio,
  input wire bmfs_pkg::bmfs_prio_t busPrio,
  // activation request
  output logic activate,
  output logic pending
);
  import bmfs_pkg::*;
  bmfs_state_t state_reg;
  bmfs_state_t state_next;
  // lower number means higher priority; blocked while core is more urgent
  wire logic blocked = (curPrio < busPrio);
  // hold fault pending until higher-priority handlers are done
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BMFS_IDLE: if (faultIn) state_next = blocked ? BMFS_PEND : BMFS_FIRE;
      BMFS_PEND: if (!blocked) state_next = BMFS_FIRE;
      BMFS_FIRE: state_next = BMFS_IDLE;
      default: state_next = BMFS_IDLE;
    endcase
  end
  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= BMFS_IDLE;
      activate <= 1'b0;
      pending <= 1'b0;
    end else begin
      state_reg <= state_next;
      activate <= (state_next == BMFS_FIRE);
      pending <= (state_next == BMFS_PEND);
    end
  end
endmodule
`default_nettype wire

// >>> bench/bmfs_flags_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module bmfs_flags_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // fault side
  input wire logic impreciseErr,
  input wire logic busFaultActivate,
  input wire logic busFaultPending,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // write access strobe
  wire logic wrAcc = psel && penable && pwrite;
  // bus timing and decode
  ready_on_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_cause_a: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  idle_rdata_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  unmapped_err_a: assert property (pready && paddr > 12'h018 |-> pslverr)
    else $error("unmapped access accepted");
  resv_zero_a: assert property (
    pready && !pwrite && paddr == 12'h000 |-> prdata[6:5] == 2'h0)
    else $error("reserved bits not zero");
  // fault activation and interrupt level
  act_cause_a: assert property (
    $rose(busFaultActivate) |-> $past(impreciseErr, 2) || $past(busFaultPending))
    else $error("activation without cause");
  irq_hold_a: assert property ($fell(irq) |-> $past(wrAcc) || $past(wrAcc, 2))
    else $error("irq dropped without write");
endmodule
`default_nettype wire

// >>> bench/bmfs_flags_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module bmfs_flags_tb_top;
  import bmfs_pkg::*;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, irq, se;
  logic busFaultActivate, busFaultPending;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, preciseAddr, mmDataAddr, rd;
  logic [6:0] evs;
  bmfs_prio_t curPrio;
  int errors, num_checks, i;
  bmfs_flags bmfs_flags_inst (
    .clk(clk),
    .nrst(nrst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .impreciseErr(evs[6]),
    .preciseErr(evs[5]),
    .preciseAddr(preciseAddr),
    .fetchErr(evs[4]),
    .fetchIssue(evs[3]),
    .fetchDiscard(evs[2]),
    .mmDataViol(evs[1]),
    .mmDataAddr(mmDataAddr),
    .stackViol(evs[0]),
    .curPrio(curPrio),
    .busFaultActivate(busFaultActivate),
    .busFaultPending(busFaultPending),
    .irq(irq)
  );
  // clock
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // compare and verdict
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // apb transfer, answer taken in the ready cycle
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) errors++;
    rd = prdata;
    se = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
    xfer(0, a, 32'h0);
    chk(n, e, rd);
  endtask
  // one-cycle fault event pulse
  task pulse(input logic [6:0] m);
    @(posedge clk) evs <= m;
    @(posedge clk) evs <= 7'h0;
  endtask
  // main sequence
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata, evs, curPrio} = '0;
    {preciseAddr, mmDataAddr} = {32'h12345670, 32'h0000abc8};
    repeat (8) @(posedge clk);
    nrst <= 1;
    rdchk("status", 12'h000, 32'h0);
    pulse(7'h20);
    rdchk("status", 12'h000, 32'h200);
    rdchk("bfaddr", 12'h004, 32'h12345670);
    pulse(7'h40);
    rdchk("status", 12'h000, 32'h600);
    pulse(7'h10);
    pulse(7'h04);
    pulse(7'h08);
    rdchk("status", 12'h000, 32'h600);
    pulse(7'h10);
    pulse(7'h08);
    rdchk("status", 12'h000, 32'h700);
    rdchk("bfaddr", 12'h004, 32'h12345670);
    pulse(7'h02);
    rdchk("status", 12'h000, 32'h780);
    mmDataAddr <= 32'h0;
    pulse(7'h03);
    rdchk("status", 12'h000, 32'h790);
    rdchk("memfault_address_reg", 12'h008, 32'h0000abc8);
    xfer(1, 12'h000, 32'h80);
    rdchk("status", 12'h000, 32'h710);
    xfer(1, 12'h000, 32'h0);
    rdchk("status", 12'h000, 32'h710);
    xfer(1, 12'h000, 32'h200);
    rdchk("status", 12'h000, 32'h510);
    xfer(1, 12'h000, 32'hffffffff);
    rdchk("status", 12'h000, 32'h0);
    rdchk("irqstat", 12'h00c, 32'h1f);
    chk("irq", 32'h0, 32'(irq));
    xfer(1, 12'h010, 32'h1);
    repeat (2) @(negedge clk);
    chk("irq", 32'h1, 32'(irq));
    xfer(1, 12'h014, 32'h1);
    repeat (2) @(negedge clk);
    chk("irq", 32'h0, 32'(irq));
    rdchk("irqstat", 12'h00c, 32'h1e);
    xfer(1, 12'h018, 32'h10);
    curPrio <= 8'h04;
    pulse(7'h40);
    repeat (4) @(negedge clk);
    chk("pending", 32'h1, 32'(busFaultPending));
    chk("activate", 32'h0, 32'(busFaultActivate));
    @(posedge clk) curPrio <= 8'h20;
    i = 0;
    do @(negedge clk); while (busFaultActivate !== 1'b1 && ++i < 10);
    chk("activate", 32'h1, 32'(busFaultActivate));
    rdchk("unmapped", 12'h020, 32'h0);
    chk("slverr", 32'h1, 32'(se));
    stop_test();
  end
  // watchdog
  initial begin
    #50000;
    errors++;
    stop_test();
  end
endmodule
bind bmfs_flags bmfs_flags_assertions bmfs_flags_assertions_inst (
  .clk(clk),
  .nrst(nrst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .impreciseErr(impreciseErr),
  .busFaultActivate(busFaultActivate),
  .busFaultPending(busFaultPending),
  .irq(irq)
);
`default_nettype wire
